// *** dv/mrc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module mrc_host_model
   import mrc_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic [mrc_pkg::MRC_DATA_W-1:0] rdata,
   output logic      [mrc_pkg::MRC_ADDR_W-1:0] addr,
   output logic      [mrc_pkg::MRC_DATA_W-1:0] wdata,
   output logic                                wr,
   output logic                                rd,
   output logic                                direction_pin
);
   initial begin
      addr          = 5'h00;
      wdata         = 16'h0000;
      wr            = 1'b0;
      rd            = 1'b0;
      direction_pin = 1'b0;
   end
   // No speed input here, so stopping is always the last step
   task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      wdata <= ~d; // Idle bus never shows the last word
   endtask
   task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      addr <= ~a;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic set_pin(input logic v);
      @(posedge clk);
      direction_pin <= v;
   endtask
endmodule // mrc_host_model
`default_nettype wire

// *** dv/test_motor_run_control_bits.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_motor_run_control_bits;
   import mrc_pkg::*;
   typedef struct packed {logic dir_bit; logic pin; logic fwd;} mrc_row_t;
   logic        clk;
   logic        reset_n;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        wr;
   logic        rd;
   logic        dir_pin;
   logic [6:0]  ev;
   logic        excite;
   logic        forward;
   logic        low_side_on;
   logic        all_off;
   logic        restart_pulse;
   int          err_count;
   int          n_checks;
   int          cycles;
   int          n_restart;
   int          n0;
   mrc_row_t    rows [4];
   mrc_run_ctrl dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .direction_pin(dir_pin), .sync_loss_fault(ev[0]),
      .soft_overcurrent_protection(ev[1]), .hard_overcurrent_protection(ev[2]),
      .por_event(ev[3]), .memory_error_event(ev[4]), .watchdog_event(ev[5]),
      .nvm_write_done(ev[6]), .excite(excite), .forward(forward),
      .low_side_on(low_side_on), .all_off(all_off), .restart_pulse(restart_pulse));
   mrc_host_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .direction_pin(dir_pin));
   // ----------------------------------------
   // Clock, timeout and pulse counting
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (restart_pulse === 1'b1) n_restart++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk1(input string w, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %b seen %b", w, e, g);
      end
   endtask
   task automatic chk16(input string w, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask
   // Mask hides flags whose setting is not pinned down
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
      logic [15:0] d;
      host_u.read_reg(a, d);
      chk16("rdata", e, d & m);
   endtask
   // Ends mid-cycle so outputs are looked at once settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev <= 7'h01 << i;
      @(posedge clk);
      ev <= 7'h00;
   endtask
   task automatic run(input logic [15:0] v, input int n);
      host_u.write_reg(MRC_REG_RUN, v);
      cyc(n);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rows = '{'{1'b0, 1'b0, 1'b1}, '{1'b0, 1'b1, 1'b0}, '{1'b1, 1'b0, 1'b0}, '{1'b1, 1'b1, 1'b1}};
      reset_n = 1'b0;
      ev = 7'h00;
      cyc(6);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         host_u.set_pin(rows[i].pin);
         run({11'h000, 1'b1, 2'b00, rows[i].dir_bit, 1'b0}, 1);
         @(negedge clk);
         chk1("forward", rows[i].fwd, forward);
      end
      $display("direction table done");
      run(16'h0011, 3);
      reset_n <= 1'b0;
      cyc(2);
      reset_n <= 1'b1;
      @(negedge clk);
      chk1("excite", 1'b0, excite);
      rd_chk(MRC_REG_RUN, 16'h0010, 16'hFFFF);
      rd_chk(MRC_REG_MASK, 16'h0000, 16'hFFFF);
      rd_chk(5'h00, 16'h0000, 16'hFFFF);
      host_u.write_reg(MRC_REG_RUN, 16'hFC10);
      rd_chk(MRC_REG_RUN, 16'h0010, 16'hFFFF);
      $display("reset and read format done");
      run(16'h0015, 2);
      chk1("excite", 1'b1, excite);
      cyc(200);
      chk1("excite", 1'b1, excite);
      chk1("low_side_on", 1'b0, low_side_on);
      cyc(100);
      chk1("low_side_on", 1'b1, low_side_on);
      run(16'h0014, 2);
      chk1("low_side_on", 1'b0, low_side_on);
      chk1("excite", 1'b0, excite);
      $display("run and brake done");
      run(16'h0009, 300);
      n0 = n_restart;
      pulse(2);
      cyc(4);
      chk1("restart", 1'b1, n_restart == n0 + 1);
      chk1("excite", 1'b1, excite);
      run(16'h0010, 2);
      run(16'h0001, 300);
      n0 = n_restart;
      pulse(0);
      cyc(4);
      chk1("excite", 1'b0, excite);
      chk1("restart", 1'b1, n_restart == n0);
      run(16'h0010, 2);
      $display("restart select done");
      run(16'h0011, 300);
      pulse(1);
      cyc(3);
      chk1("all_off", 1'b1, all_off);
      rd_chk(MRC_REG_RUN, 16'h0811, 16'h7FFF);
      host_u.write_reg(MRC_REG_RUN, 16'h0011);
      rd_chk(MRC_REG_RUN, 16'h0811, 16'h7FFF);
      run(16'h0010, 2);
      run(16'h0001, 300);
      pulse(1);
      cyc(3);
      chk1("all_off", 1'b0, all_off);
      chk1("excite", 1'b1, excite);
      run(16'h0005, 2);
      chk1("low_side_on", 1'b1, low_side_on);
      run(16'h0010, 2);
      for (int i = 3; i < 6; i++) begin
         pulse(i);
         cyc(2);
         rd_chk(MRC_REG_MASK, 16'h8000 >> (i - 2), 16'h7FFF);
         run(16'h0010, 2);
      end
      $display("fault flags done");
      repeat (1023) pulse(6);
      rd_chk(MRC_REG_MASK, 16'h0000, 16'h7C00);
      rd_chk(MRC_REG_NVM, 16'h03FF, 16'hFFFF);
      pulse(6);
      cyc(2);
      rd_chk(MRC_REG_MASK, 16'h0400, 16'h7C00);
      run(16'h0010, 2);
      rd_chk(MRC_REG_MASK, 16'h0400, 16'h7C00);
      pulse(6);
      cyc(2);
      rd_chk(MRC_REG_NVM, 16'h0400, 16'hFFFF);
      $display("write wear done");
      final_report();
   end
endmodule // test_motor_run_control_bits
`default_nettype wire

// *** hw/mrc_flag.sv ***
`timescale 1ns/100ps
`default_nettype none
// Sticky fault flag; set wins over clear
module mrc_flag (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic set,
   input  wire logic clear,
   output logic      flag
);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end
endmodule // mrc_flag
`default_nettype wire

// *** hw/mrc_pkg.sv ***
package mrc_pkg;
   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [4:0] MRC_REG_NVM    = 5'h1C;
   localparam logic [4:0] MRC_REG_MASK   = 5'h1D;
   localparam logic [4:0] MRC_REG_DIAG   = 5'h1E;
   localparam logic [4:0] MRC_REG_RUN    = 5'h1F;
   localparam int         MRC_ADDR_W     = 5;
   localparam int         MRC_DATA_W     = 16;
   localparam int         MRC_SET_W      = 10;
   localparam int         MRC_FLAG_W     = 6;
   // ------------------------------------------------------------
   // Run register fields
   // ------------------------------------------------------------
   localparam int MRC_RUN_BIT      = 0;
   localparam int MRC_DIR_BIT      = 1;
   localparam int MRC_BRAKE_BIT    = 2;
   localparam int MRC_RESTART_BIT  = 3;
   localparam int MRC_FSTOP_BIT    = 4;
   localparam logic [9:0] MRC_RUN_RESET  = 10'h010;
   localparam logic [9:0] MRC_MASK_RESET = 10'h000;
   localparam logic [9:0] MRC_DIAG_RESET = 10'h000;
   // ------------------------------------------------------------
   // Fault flag positions within the 6-bit field
   // ------------------------------------------------------------
   localparam int MRC_FF_GENERAL = 5;
   localparam int MRC_FF_POR     = 4;
   localparam int MRC_FF_MEM     = 3;
   localparam int MRC_FF_WDOG    = 2;
   localparam int MRC_FF_SOC     = 1;
   localparam int MRC_FF_WEAR    = 0;
   localparam logic [10:0] MRC_WEAR_LIMIT = 11'h3FF;
   // ------------------------------------------------------------
   // Drive states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MRC_ST_STOP    = 3'b000,
      MRC_ST_STARTUP = 3'b001,
      MRC_ST_DRIVE   = 3'b010,
      MRC_ST_BRAKE   = 3'b011,
      MRC_ST_COAST   = 3'b100
   } mrc_state_t;
   localparam logic [7:0] MRC_STARTUP_CYC = 8'hFF;
endpackage : mrc_pkg

// *** hw/mrc_run_ctrl.sv ***
// Function
// R1: Restart select 0: no restart on sync loss, motor coasts.
// R2: Restart select 1 with run and no brake: restart after sync loss or overcurrent.
// R3: Brake bit acts only while run bit is 1.
// R4: Run and brake both 1: all three low sides on.
// R5: Brake bit ignored during startup sequence.
// R6: Forward when direction bit equals direction pin, else reverse.
// R7: Run 0 stops excitation; run 1 starts the motor.
// R8: Reads return fault flags in top 6 bits, settings in low 10.
// R9: Flags 15..10: general, power-on reset, memory, watchdog, overcurrent, wear.
// R10: Host holds direction, reset, serial pins low until logic supply is up.
// R11: Host lowers speed command before stopping the motor.
// R12: Fault-stop select 0 keeps driving; 1 turns all transistors off.
// R13: Count nonvolatile writes; beyond 1023 set wear flag permanently.
// R14: Fault flag field is read-only to host writes.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mrc_run_ctrl
   import mrc_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic [mrc_pkg::MRC_ADDR_W-1:0] addr,
   input  wire logic [mrc_pkg::MRC_DATA_W-1:0] wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output logic      [mrc_pkg::MRC_DATA_W-1:0] rdata,
   input  wire logic                          direction_pin,
   input  wire logic                          sync_loss_fault,
   input  wire logic                          soft_overcurrent_protection,
   input  wire logic                          hard_overcurrent_protection,
   input  wire logic                          por_event,
   input  wire logic                          memory_error_event,
   input  wire logic                          watchdog_event,
   input  wire logic                          nvm_write_done,
   output logic                               excite,
   output logic                               forward,
   output logic                               low_side_on,
   output logic                               all_off,
   output logic                               restart_pulse
);
   import mrc_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [9:0]  run_reg;
      logic [9:0]  mask_reg;
      logic [9:0]  diag_reg;
      logic [10:0] wear_cnt;
      logic        wear;
      logic        fault_hold;
      mrc_state_t  st;
      logic [7:0]  tmr;
      logic        restart;
      logic [15:0] rdata;
   } mrc_regs_t;

   mrc_regs_t r;
   mrc_regs_t next_r;
   logic [5:0] flags;
   logic       any_fault;
   logic       clr_flags;
   logic       oc_any;
   logic       run_bit;
   logic       brake_bit;

   // ------------------------------------------------------------
   // Sticky fault flags
   // ------------------------------------------------------------
   // Flags clear only by a write of 0 to the run bit; set still wins
   assign clr_flags = wr && (addr == MRC_REG_RUN) && !wdata[MRC_RUN_BIT];
   assign oc_any    = soft_overcurrent_protection | hard_overcurrent_protection;
   assign any_fault = sync_loss_fault | oc_any | por_event | memory_error_event
                    | watchdog_event;

   mrc_flag u_ff (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (any_fault),
      .clear   (clr_flags),
      .flag    (flags[MRC_FF_GENERAL])
   );
   mrc_flag u_por (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (por_event),
      .clear   (clr_flags),
      .flag    (flags[MRC_FF_POR])
   );
   mrc_flag u_mem (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (memory_error_event),
      .clear   (clr_flags),
      .flag    (flags[MRC_FF_MEM])
   );
   mrc_flag u_wdog (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (watchdog_event),
      .clear   (clr_flags),
      .flag    (flags[MRC_FF_WDOG])
   );
   mrc_flag u_soc (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (soft_overcurrent_protection),
      .clear   (clr_flags),
      .flag    (flags[MRC_FF_SOC])
   );
   assign flags[MRC_FF_WEAR] = r.wear; // R13

   assign run_bit   = r.run_reg[MRC_RUN_BIT];
   assign brake_bit = r.run_reg[MRC_BRAKE_BIT];

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.restart = 1'b0;
      next_r.rdata = '0;
      if (wr) begin
         // Upper six bits of wdata are dropped: flags are read-only
         case (addr)
            MRC_REG_RUN:  next_r.run_reg  = wdata[MRC_SET_W-1:0]; // R14
            MRC_REG_MASK: next_r.mask_reg = wdata[MRC_SET_W-1:0]; // R14
            MRC_REG_DIAG: next_r.diag_reg = wdata[MRC_SET_W-1:0]; // R14
            default:      next_r.run_reg  = r.run_reg;
         endcase
      end
      if (rd) begin
         case (addr)
            MRC_REG_RUN:  next_r.rdata = {flags, r.run_reg};  // R8 R9
            MRC_REG_MASK: next_r.rdata = {flags, r.mask_reg}; // R8 R9
            MRC_REG_DIAG: next_r.rdata = {flags, r.diag_reg}; // R8 R9
            MRC_REG_NVM:  next_r.rdata = {flags, r.wear_cnt[MRC_SET_W-1:0]}; // R8
            default:      next_r.rdata = {flags, {MRC_SET_W{1'b0}}}; // R8
         endcase
      end
      // Counter saturates once past the limit so the flag cannot wrap away
      if (nvm_write_done && !r.wear_cnt[MRC_SET_W]) begin
         next_r.wear_cnt = r.wear_cnt + 11'h001; // R13
      end
      if (r.wear_cnt > MRC_WEAR_LIMIT) begin
         next_r.wear = 1'b1; // R13
      end
      if ((any_fault) && r.run_reg[MRC_FSTOP_BIT]) begin
         next_r.fault_hold = 1'b1; // R12
      end
      if (!run_bit) begin
         next_r.fault_hold = 1'b0;
      end
      case (r.st)
         MRC_ST_STOP: begin
            next_r.tmr = '0;
            if (run_bit) begin
               next_r.st = MRC_ST_STARTUP; // R7
            end
         end
         MRC_ST_STARTUP: begin
            // Startup excitation runs whatever the brake bit says
            next_r.tmr = r.tmr + 8'h01; // R5
            if (!run_bit) begin
               next_r.st = MRC_ST_STOP; // R7
            end else if (r.tmr == MRC_STARTUP_CYC) begin
               next_r.st = brake_bit ? MRC_ST_BRAKE : MRC_ST_DRIVE; // R5
            end
         end
         MRC_ST_DRIVE: begin
            if (!run_bit) begin
               next_r.st = MRC_ST_STOP; // R7
            end else if (brake_bit) begin
               next_r.st = MRC_ST_BRAKE; // R4
            end else if (sync_loss_fault || oc_any) begin
               if (r.run_reg[MRC_RESTART_BIT]) begin
                  next_r.st = MRC_ST_STARTUP; // R2
                  next_r.tmr = '0;
                  next_r.restart = 1'b1; // R2
               end else if (sync_loss_fault) begin
                  next_r.st = MRC_ST_COAST; // R1
               end
            end
         end
         MRC_ST_BRAKE: begin
            if (!run_bit) begin
               next_r.st = MRC_ST_STOP; // R3
            end else if (!brake_bit) begin
               next_r.st = MRC_ST_DRIVE; // R4
            end
         end
         MRC_ST_COAST: begin
            // Only a stop command leaves coasting
            if (!run_bit) begin
               next_r.st = MRC_ST_STOP; // R1
            end
         end
         default: next_r.st = MRC_ST_STOP;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r.run_reg    <= MRC_RUN_RESET;
         r.mask_reg   <= MRC_MASK_RESET;
         r.diag_reg   <= MRC_DIAG_RESET;
         r.wear_cnt   <= '0;
         r.wear       <= 1'b0;
         r.fault_hold <= 1'b0;
         r.st         <= MRC_ST_STOP;
         r.tmr        <= '0;
         r.restart    <= 1'b0;
         r.rdata      <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata         = r.rdata;
   assign restart_pulse = r.restart;
   assign forward       = (r.run_reg[MRC_DIR_BIT] == direction_pin); // R6
   assign all_off       = r.fault_hold; // R12
   assign excite        = ((r.st == MRC_ST_STARTUP) || (r.st == MRC_ST_DRIVE))
                          && !r.fault_hold; // R7
   assign low_side_on   = (r.st == MRC_ST_BRAKE) && run_bit && !r.fault_hold; // R3 R4

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_stop_no_excite: assert property (@(posedge clk) disable iff (!reset_n) // R7
      !run_bit |=> (!excite && !low_side_on))
      else $error("excitation while run bit clear");
   a_brake_needs_run: assert property (@(posedge clk) disable iff (!reset_n) // R3
      low_side_on |-> (run_bit && $past(run_bit)))
      else $error("brake without run");
   a_brake_engages: assert property (@(posedge clk) disable iff (!reset_n) // R4
      (r.st == MRC_ST_DRIVE && run_bit && brake_bit && !r.fault_hold && !wr && !any_fault)
      |=> low_side_on)
      else $error("brake did not engage");
   a_dir_map: assert property (@(posedge clk) disable iff (!reset_n) // R6
      forward == !(r.run_reg[MRC_DIR_BIT] ^ direction_pin))
      else $error("direction mapping wrong");
   a_no_restart: assert property (@(posedge clk) disable iff (!reset_n) // R1
      (r.st == MRC_ST_DRIVE && sync_loss_fault && !r.run_reg[MRC_RESTART_BIT]
       && run_bit && !brake_bit) |=> (r.st == MRC_ST_COAST && !restart_pulse))
      else $error("restart without select");
   a_restart_go: assert property (@(posedge clk) disable iff (!reset_n) // R2
      (r.st == MRC_ST_DRIVE && oc_any && r.run_reg[MRC_RESTART_BIT]
       && run_bit && !brake_bit) |=> restart_pulse ##1 !restart_pulse)
      else $error("restart missing");
   a_startup_brake: assert property (@(posedge clk) disable iff (!reset_n) // R5
      (r.st == MRC_ST_STARTUP && r.tmr != MRC_STARTUP_CYC)
      |=> (r.st != MRC_ST_BRAKE && !low_side_on))
      else $error("brake bit acted in startup");
   a_read_format: assert property (@(posedge clk) disable iff (!reset_n) // R8
      (rd && addr == MRC_REG_RUN && !wr && !any_fault && !clr_flags)
      |=> rdata == {$past(flags), $past(r.run_reg)})
      else $error("read format wrong");
   a_fault_stop: assert property (@(posedge clk) disable iff (!reset_n) // R12
      (any_fault && r.run_reg[MRC_FSTOP_BIT] && run_bit && !wr) |=> (all_off && !excite))
      else $error("fault stop failed");
   a_wear_sticky: assert property (@(posedge clk) disable iff (!reset_n) // R13
      flags[MRC_FF_WEAR] |=> flags[MRC_FF_WEAR])
      else $error("wear flag dropped");
   a_soc_flag: assert property (@(posedge clk) disable iff (!reset_n) // R9
      soft_overcurrent_protection |=> (flags[MRC_FF_SOC] && flags[MRC_FF_GENERAL]))
      else $error("overcurrent flag not set");

   // ------------------------------------------------------------
   // Checks of start, restart, hold, flag and read-data paths
   // ------------------------------------------------------------
   a_restart_idle: assert property (@(posedge clk) disable iff (!reset_n) // R2
      restart_pulse |-> (r.st == MRC_ST_STARTUP && r.tmr == '0))
      else $error("restart pulse outside fresh startup");
   a_coast_holds: assert property (@(posedge clk) disable iff (!reset_n) // R1
      (r.st == MRC_ST_COAST && run_bit) |=> (r.st == MRC_ST_COAST && !excite))
      else $error("coasting motor restarted");
   a_stop_to_start: assert property (@(posedge clk) disable iff (!reset_n) // R7
      (r.st == MRC_ST_STOP && run_bit) |=> (r.st == MRC_ST_STARTUP))
      else $error("run bit did not start motor");
   // Flags other than wear may only move by a fault event or a run-bit clear
   a_flag_ro: assert property (@(posedge clk) disable iff (!reset_n) // R14
      (!any_fault && !clr_flags)
      |=> (flags[MRC_FF_GENERAL:MRC_FF_SOC] == $past(flags[MRC_FF_GENERAL:MRC_FF_SOC])))
      else $error("fault flags changed by write");
   a_wear_sets: assert property (@(posedge clk) disable iff (!reset_n) // R13
      (r.wear_cnt > MRC_WEAR_LIMIT) |=> flags[MRC_FF_WEAR])
      else $error("wear flag not set");
   a_hold_release: assert property (@(posedge clk) disable iff (!reset_n) // R12
      !run_bit |=> !all_off)
      else $error("fault hold kept with run clear");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!reset_n) // R8
      !rd |=> (rdata == '0))
      else $error("read data outside read cycle");

endmodule // mrc_run_ctrl
`default_nettype wire
